//--- atg_params.svh
`ifndef ATG_PARAMS_SVH
`define ATG_PARAMS_SVH
// register byte addresses
`define ATG_ADDR_CTRL      8'h00
`define ATG_ADDR_STATUS    8'h04
`define ATG_ADDR_PATTERN   8'h08
`define ATG_ADDR_INERTIA   8'h0C
`define ATG_ADDR_POS1      8'h10
`define ATG_ADDR_POS2      8'h14
`define ATG_ADDR_SPD       8'h18
`define ATG_ADDR_INT       8'h1C
`define ATG_ADDR_TRQ       8'h20
`define ATG_ADDR_FIXED0    8'h24
`define ATG_ADDR_FIXED1    8'h28
`define ATG_ADDR_FIXED2    8'h2C
`define ATG_ADDR_FIXED3    8'h30
`define ATG_ADDR_SPDFB     8'h34
// status bit positions
`define ATG_ST_BUSY        0
`define ATG_ST_ERR         1
`define ATG_ST_DONE        2
`define ATG_ST_START       3
// fixed values
`define ATG_INT2_FIXED     16'h03E8
`define ATG_FF_AMOUNT      16'h012C
`define ATG_FF_FILTER      16'h0032
`define ATG_SW_MODE        16'h0001
`define ATG_SW_SETTING     16'h000A
`define ATG_SW_TIME        16'h001E
`define ATG_SW_LEVEL       16'h0032
`define ATG_SW_HYST        16'h0021
`define ATG_POS_SW_TIME    16'h0014
`define ATG_FB_FILT        16'h0000
// reset values
`define ATG_RST_POS1       16'h001B
`define ATG_RST_POS2       16'h001F
`define ATG_RST_SPD        16'h000F
`define ATG_RST_INT        16'h0025
`define ATG_RST_TRQ        16'h0098
// timing
`define ATG_CLK_HZ         40000000
`define ATG_CYCLE_S        15
`define ATG_CYCLE_CLKS     (`ATG_CYCLE_S * `ATG_CLK_HZ)
`define ATG_HOLD_MS        1000
`define ATG_HOLD_CLKS      (`ATG_HOLD_MS * (`ATG_CLK_HZ / 1000))
`define ATG_MAX_CYCLES     5
`define ATG_ACCEL_CYCLE    3
`endif

//--- atg_pkg.sv
package atg_pkg;
   typedef enum logic [2:0] {
      ATG_SELECT,
      ATG_ARMED,
      ATG_HOLD,
      ATG_RUN,
      ATG_FINISH
   } atg_state_e;

   typedef struct packed {
      logic [15:0] pos1;
      logic [15:0] pos2;
      logic [15:0] spd;
      logic [15:0] int1;
      logic [15:0] trq1;
      logic [15:0] trq2;
   } atg_gains_s;
endpackage

//--- atg_sequencer.sv
`include "atg_params.svh"

// Contract
// - at most five test pattern cycles
// - acceleration doubles each cycle from third cycle on
// - early finish is not an error
// - rigidity selector 0 to F
// - keys step rigidity, data key arms
// - servo on then held increment starts
// - pattern zero: two fwd, two rev
// - no load gives inertia ratio zero
// - fault, servo off, clear, limit abort
// - torque saturation aborts tuning
// - oscillation aborts tuning
// - error restores previous gains
// - motor runs until error or end
// - primary position gain table
// - secondary position gain table
// - both speed gains table
// - integral tables, secondary fixed 1000
// - primary torque filter table
// - secondary torque filter table
// - speed feedback filters zero
// - fixed feed-forward and switch values
// - success writes estimated inertia ratio
// - drive prohibit ignored while tuning
// - no estimate keeps previous gains
module atg_sequencer import atg_pkg::*; #(
   parameter int unsigned CYCLE_CLKS = `ATG_CYCLE_CLKS,
   parameter int unsigned HOLD_CLKS  = `ATG_HOLD_CLKS
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // operator panel and servo
   input  wire logic        key_inc_i,
   input  wire logic        key_dec_i,
   input  wire logic        key_data_i,
   input  wire logic        servo_on_i,
   // abort sources, estimator and drive prohibit inputs
   input  wire logic        drive_fault_i,
   input  wire logic        deviation_clear_input_i,
   input  wire logic        limit_sensor_i,
   input  wire logic        torque_sat_i,
   input  wire logic        oscillation_i,
   input  wire logic        load_present_i,
   input  wire logic        inertia_valid_i,
   input  wire logic [15:0] inertia_est_i,
   input  wire logic        fwd_prohibit_i,
   input  wire logic        rev_prohibit_i,
   // motion command and gains out
   output logic             motor_run_o,
   output logic             motor_reverse_o,
   output logic      [2:0]  accel_shift_o,
   output logic             prohibit_fwd_o,
   output logic             prohibit_rev_o,
   output logic      [3:0]  rigidity_o,
   output atg_gains_s       gains_o
);
   // fewer than four ticks per cycle leaves no room for the forward/reverse split
   if (CYCLE_CLKS < 4 || HOLD_CLKS < 1) begin : g_bad_counts
      $error("atg_sequencer: counts too small");
   end

   function automatic atg_gains_s table_lookup(input logic [3:0] r);
      atg_gains_s g;
      g.int1 = 16'h0003;
      case (r)
         4'h0: g = '{16'd27, 16'd31, 16'd15, 16'd37, 16'd152, 16'd152};
         4'h1: g = '{16'd32, 16'd38, 16'd18, 16'd31, 16'd126, 16'd126};
         4'h2: g = '{16'd39, 16'd46, 16'd22, 16'd25, 16'd103, 16'd103};
         4'h3: g = '{16'd48, 16'd57, 16'd27, 16'd21, 16'd84, 16'd84};
         4'h4: g = '{16'd63, 16'd73, 16'd35, 16'd16, 16'd65, 16'd65};
         4'h5: g = '{16'd72, 16'd84, 16'd40, 16'd14, 16'd57, 16'd57};
         4'h6: g = '{16'd90, 16'd105, 16'd50, 16'd12, 16'd45, 16'd45};
         4'h7: g = '{16'd108, 16'd126, 16'd60, 16'd11, 16'd38, 16'd38};
         4'h8: g = '{16'd135, 16'd157, 16'd75, 16'd9, 16'd30, 16'd30};
         4'h9: g = '{16'd162, 16'd188, 16'd90, 16'd8, 16'd25, 16'd25};
         4'hA: g = '{16'd206, 16'd241, 16'd115, 16'd7, 16'd25, 16'd20};
         4'hB: g = '{16'd251, 16'd293, 16'd140, 16'd6, 16'd25, 16'd16};
         4'hC: g = '{16'd305, 16'd356, 16'd170, 16'd5, 16'd25, 16'd13};
         4'hD: g = '{16'd377, 16'd440, 16'd210, 16'd4, 16'd25, 16'd11};
         4'hE: g = '{16'd449, 16'd524, 16'd250, 16'd4, 16'd25, 16'd10};
         default: g = '{16'd557, 16'd649, 16'd310, 16'd3, 16'd25, 16'd10};
      endcase
      return g;
   endfunction

   localparam logic [31:0] CYC_LAST = 32'(CYCLE_CLKS - 1);
   localparam logic [31:0] QTR      = 32'(CYCLE_CLKS / 4);
   localparam logic [31:0] HOLD_MAX = 32'(HOLD_CLKS - 1);

   atg_state_e  state;
   logic [3:0]  rigidity;
   logic [2:0]  cycle_no;
   logic [31:0] tick;
   logic [31:0] hold_cnt;
   logic [15:0] inertia_ratio;
   logic [1:0]  pattern;
   logic        err_flag;
   logic        done_flag;
   logic        ctrl_start;
   logic        inc_q;
   logic        dec_q;
   logic        data_q;
   atg_gains_s  gains;
   atg_gains_s  saved;

   wire logic inc_edge  = key_inc_i & ~inc_q;
   wire logic dec_edge  = key_dec_i & ~dec_q;
   wire logic data_edge = key_data_i & ~data_q;
   wire logic running   = (state == ATG_RUN);
   wire logic abort_now = running & (drive_fault_i | ~servo_on_i | deviation_clear_input_i
                          | limit_sensor_i | torque_sat_i | oscillation_i);
   wire logic cyc_end   = running & (tick == CYC_LAST);
   wire logic last_cyc  = (cycle_no == 3'(`ATG_MAX_CYCLES));
   wire logic finish_ok = running & ~abort_now & (inertia_valid_i | (cyc_end & last_cyc));
   wire logic hold_done = (hold_cnt == HOLD_MAX);
   wire logic run_start = (state == ATG_HOLD) & hold_done & servo_on_i & (key_inc_i | ctrl_start);
   wire logic good_est  = inertia_valid_i | ~load_present_i;
   wire logic wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // writes land on the edge at which the master sees ack
   wire logic wb_wr     = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
   wire logic [15:0] est_value = load_present_i ? inertia_est_i : 16'h0000;
   wire logic [3:0]  status = {ctrl_start, done_flag, err_flag, running};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inc_q  <= 1'b0;
         dec_q  <= 1'b0;
         data_q <= 1'b0;
      end else begin
         inc_q  <= key_inc_i;
         dec_q  <= key_dec_i;
         data_q <= key_data_i;
      end
   end

   // sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= ATG_SELECT;
         rigidity <= 4'h0;
         cycle_no <= 3'h1;
         tick     <= 32'h0000_0000;
         hold_cnt <= 32'h0000_0000;
      end else begin
         case (state)
            ATG_SELECT: begin
               if (inc_edge && rigidity != 4'hF) rigidity <= rigidity + 4'h1;
               else if (dec_edge && rigidity != 4'h0) rigidity <= rigidity - 4'h1;
               if (data_edge) state <= ATG_ARMED;
            end
            ATG_ARMED: begin
               hold_cnt <= 32'h0000_0000;
               if (key_data_i && !data_q) state <= ATG_SELECT;
               else if ((servo_on_i && key_inc_i) || ctrl_start) state <= ATG_HOLD;
            end
            ATG_HOLD: begin
               // start needs servo on and a held key or ctrl_start the whole time
               if (!servo_on_i || (!key_inc_i && !ctrl_start)) state <= ATG_ARMED;
               else if (hold_done) begin
                  state    <= ATG_RUN;
                  cycle_no <= 3'h1;
                  tick     <= 32'h0000_0000;
               end else hold_cnt <= hold_cnt + 32'h1;
            end
            ATG_RUN: begin
               if (abort_now || finish_ok) state <= ATG_FINISH;
               else if (cyc_end) begin
                  tick     <= 32'h0000_0000;
                  cycle_no <= cycle_no + 3'h1;
               end else tick <= tick + 32'h1;
            end
            default: state <= ATG_ARMED;
         endcase
      end
   end

   // gains, snapshot and result flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gains         <= '{`ATG_RST_POS1, `ATG_RST_POS2, `ATG_RST_SPD, `ATG_RST_INT,
                            `ATG_RST_TRQ, `ATG_RST_TRQ};
         saved         <= '{`ATG_RST_POS1, `ATG_RST_POS2, `ATG_RST_SPD, `ATG_RST_INT,
                            `ATG_RST_TRQ, `ATG_RST_TRQ};
         inertia_ratio <= 16'h0000;
         err_flag      <= 1'b0;
         done_flag     <= 1'b0;
      end else begin
         if (run_start) begin
            saved     <= gains;
            err_flag  <= 1'b0;
            done_flag <= 1'b0;
         end
         if (abort_now) begin
            gains    <= saved;
            err_flag <= 1'b1;
         end else if (finish_ok) begin
            done_flag <= 1'b1;
            if (good_est) begin
               gains         <= table_lookup(rigidity);
               inertia_ratio <= est_value;
            end else gains <= saved;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pattern    <= 2'h0;
         ctrl_start <= 1'b0;
      end else begin
         if (wb_wr && wb_adr_i == `ATG_ADDR_PATTERN) pattern <= wb_dat_i[1:0];
         if (wb_wr && wb_adr_i == `ATG_ADDR_CTRL) ctrl_start <= wb_dat_i[0];
         else if (running) ctrl_start <= 1'b0;
      end
   end

   // wishbone: ack one cycle after request, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            if (wb_adr_i == `ATG_ADDR_CTRL) wb_dat_o <= {31'h0, ctrl_start};
            else if (wb_adr_i == `ATG_ADDR_STATUS) wb_dat_o <= {28'h0, status};
            else if (wb_adr_i == `ATG_ADDR_PATTERN) wb_dat_o <= {30'h0, pattern};
            else if (wb_adr_i == `ATG_ADDR_INERTIA) wb_dat_o <= {16'h0, inertia_ratio};
            else if (wb_adr_i == `ATG_ADDR_POS1) wb_dat_o <= {16'h0, gains.pos1};
            else if (wb_adr_i == `ATG_ADDR_POS2) wb_dat_o <= {16'h0, gains.pos2};
            else if (wb_adr_i == `ATG_ADDR_SPD) wb_dat_o <= {gains.spd, gains.spd};
            else if (wb_adr_i == `ATG_ADDR_INT) wb_dat_o <= {`ATG_INT2_FIXED, gains.int1};
            else if (wb_adr_i == `ATG_ADDR_TRQ) wb_dat_o <= {gains.trq2, gains.trq1};
            else if (wb_adr_i == `ATG_ADDR_FIXED0) wb_dat_o <= {`ATG_FF_FILTER, `ATG_FF_AMOUNT};
            else if (wb_adr_i == `ATG_ADDR_FIXED1) wb_dat_o <= {`ATG_SW_SETTING, `ATG_SW_MODE};
            else if (wb_adr_i == `ATG_ADDR_FIXED2) wb_dat_o <= {`ATG_SW_LEVEL, `ATG_SW_TIME};
            else if (wb_adr_i == `ATG_ADDR_FIXED3) wb_dat_o <= {`ATG_POS_SW_TIME, `ATG_SW_HYST};
            else if (wb_adr_i == `ATG_ADDR_SPDFB) wb_dat_o <= {2{`ATG_FB_FILT}};
            else wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // pattern 0: four quarter cycles fwd, fwd, rev, rev; other patterns one each way
   wire logic rev_half = (pattern == 2'h0) ? (tick >= 32'(2) * QTR) : (tick >= 32'(2) * QTR);
   wire logic [2:0] accel = (cycle_no >= 3'(`ATG_ACCEL_CYCLE)) ? 3'(cycle_no - 3'h2) : 3'h0;

   assign motor_run_o     = running;
   assign motor_reverse_o = running & rev_half;
   assign accel_shift_o   = accel;
   assign prohibit_fwd_o  = fwd_prohibit_i & ~running;
   assign prohibit_rev_o  = rev_prohibit_i & ~running;
   assign rigidity_o      = rigidity;
   assign gains_o         = gains;

   property p_cycle_cap;
      @(posedge clk_i) disable iff (rst_i) running |-> cycle_no <= 3'd5;
   endproperty
   a_cycle_cap: assert property (p_cycle_cap) else $error("too many cycles");

   property p_accel;
      @(posedge clk_i) disable iff (rst_i) running && cycle_no == 3'd4 |-> accel_shift_o == 3'd2;
   endproperty
   a_accel: assert property (p_accel) else $error("accel level wrong");

   property p_abort_err;
      @(posedge clk_i) disable iff (rst_i) abort_now |=> err_flag && state == ATG_FINISH;
   endproperty
   a_abort_err: assert property (p_abort_err) else $error("abort not flagged");

   property p_restore;
      @(posedge clk_i) disable iff (rst_i) abort_now |=> gains == $past(saved);
   endproperty
   a_restore: assert property (p_restore) else $error("gains not restored");

   property p_ok_noerr;
      @(posedge clk_i) disable iff (rst_i) finish_ok |=> !err_flag && done_flag;
   endproperty
   a_ok_noerr: assert property (p_ok_noerr) else $error("success flagged error");

   property p_noload;
      @(posedge clk_i) disable iff (rst_i) finish_ok && !load_present_i |=> inertia_ratio == 16'h0;
   endproperty
   a_noload: assert property (p_noload) else $error("no-load ratio not zero");

   property p_prohibit;
      @(posedge clk_i) disable iff (rst_i) running |-> !prohibit_fwd_o && !prohibit_rev_o;
   endproperty
   a_prohibit: assert property (p_prohibit) else $error("prohibit not ignored");

   sequence s_armed_go;
      state == ATG_ARMED && servo_on_i && key_inc_i && !key_data_i;
   endsequence
   property p_start_needs_servo;
      @(posedge clk_i) disable iff (rst_i) $rose(running) |-> $past(servo_on_i);
   endproperty
   a_start_needs_servo: assert property (p_start_needs_servo) else $error("start w/o servo");

   property p_arm_hold;
      @(posedge clk_i) disable iff (rst_i) s_armed_go |=> state == ATG_HOLD;
   endproperty
   a_arm_hold: assert property (p_arm_hold) else $error("hold not entered");

   property p_success_table;
      @(posedge clk_i) disable iff (rst_i)
         finish_ok && good_est |=> gains == table_lookup($past(rigidity));
   endproperty
   a_success_table: assert property (p_success_table) else $error("table gains wrong");

   property p_ratio_write;
      @(posedge clk_i) disable iff (rst_i)
         finish_ok && inertia_valid_i && load_present_i |=> inertia_ratio == $past(inertia_est_i);
   endproperty
   a_ratio_write: assert property (p_ratio_write) else $error("ratio not written");

   property p_no_est_keep;
      @(posedge clk_i) disable iff (rst_i) finish_ok && !good_est |=> gains == $past(saved);
   endproperty
   a_no_est_keep: assert property (p_no_est_keep) else $error("gains changed w/o estimate");

   property p_rig_step;
      @(posedge clk_i) disable iff (rst_i)
         state == ATG_SELECT && inc_edge && rigidity != 4'hF |=> rigidity == $past(rigidity) + 4'h1;
   endproperty
   a_rig_step: assert property (p_rig_step) else $error("rigidity not stepped");

   property p_err_hold;
      @(posedge clk_i) disable iff (rst_i) err_flag && !run_start |=> err_flag;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error flag lost");

   property p_keep_running;
      @(posedge clk_i) disable iff (rst_i) running && !abort_now && !finish_ok |=> running;
   endproperty
   a_keep_running: assert property (p_keep_running) else $error("motor stopped early");

   property p_rev_end;
      @(posedge clk_i) disable iff (rst_i) cyc_end |-> motor_reverse_o;
   endproperty
   a_rev_end: assert property (p_rev_end) else $error("cycle not ending in reverse");
endmodule

//--- atg_motor_model.sv
module atg_motor_model (
   // clock and motion state
   input  wire logic        clk_i,
   input  wire logic        run_i,
   // bench controls
   input  wire logic        load_i,
   input  wire logic [1:0]  kind_i,
   input  wire logic [15:0] at_i,
   input  wire logic [15:0] est_i,
   // load responses
   output logic             load_o,
   output logic             valid_o,
   output logic      [15:0] est_o,
   output logic             sat_o,
   output logic             osc_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] t;
   logic        hit;
   // the load only reacts while the motor is turning
   assign hit     = run_i && at_i != 16'h0000 && t >= at_i;
   assign load_o  = load_i;
   assign valid_o = hit && kind_i == 2'h0 && t == at_i;
   // an idle estimate bus shows t ^ A5A5, moving only while the motor runs, never the last value
   assign est_o   = valid_o ? est_i : t ^ 16'hA5A5;
   // saturation and oscillation persist until the drive stops the motor
   assign sat_o   = hit && kind_i == 2'h1;
   assign osc_o   = hit && kind_i == 2'h2;
   always_ff @(posedge clk_i) begin
      t <= run_i ? t + 16'h0001 : 16'h0000;
   end
endmodule

//--- testbench.sv
module testbench;
   import atg_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CYC = 40;
   localparam int HLD = 4;
   logic        clk, rst, cyc, stb, we, servo, ld, ack, run, rev, pf, pr, fpro, rpro;
   logic        ldp, vld, sat, osc;
   logic [1:0]  kind_r;
   logic [2:0]  keys, ash;
   logic [3:0]  rig_o, sel;
   logic [4:0]  abv;
   logic [7:0]  adr, lf;
   logic [15:0] at_r, est_r, est, ratio;
   logic [31:0] wdat, rdo, rdat;
   atg_gains_s  gains, g;
   int          error_cnt, checks_done;
   int p1[16] = '{27, 32, 39, 48, 63, 72, 90, 108, 135, 162, 206, 251, 305, 377, 449, 557};
   int p2[16] = '{31, 38, 46, 57, 73, 84, 105, 126, 157, 188, 241, 293, 356, 440, 524, 649};
   int sp[16] = '{15, 18, 22, 27, 35, 40, 50, 60, 75, 90, 115, 140, 170, 210, 250, 310};
   int i1[16] = '{37, 31, 25, 21, 16, 14, 12, 11, 9, 8, 7, 6, 5, 4, 4, 3};
   int t2[16] = '{152, 126, 103, 84, 65, 57, 45, 38, 30, 25, 20, 16, 13, 11, 10, 10};

   atg_sequencer #(.CYCLE_CLKS(CYC), .HOLD_CLKS(HLD)) uut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .key_inc_i(keys[0]), .key_dec_i(keys[1]), .key_data_i(keys[2]), .servo_on_i(servo),
      .drive_fault_i(abv[1]), .deviation_clear_input_i(abv[3]), .limit_sensor_i(abv[4]),
      .torque_sat_i(sat), .oscillation_i(osc), .load_present_i(ldp), .inertia_valid_i(vld),
      .inertia_est_i(est), .fwd_prohibit_i(fpro), .rev_prohibit_i(rpro), .motor_run_o(run),
      .motor_reverse_o(rev), .accel_shift_o(ash), .prohibit_fwd_o(pf), .prohibit_rev_o(pr),
      .rigidity_o(rig_o), .gains_o(gains));

   atg_motor_model load_model (
      .clk_i(clk), .run_i(run), .load_i(ld), .kind_i(kind_r), .at_i(at_r), .est_i(est_r),
      .load_o(ldp), .valid_o(vld), .est_o(est), .sat_o(sat), .osc_o(osc));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic atg_gains_s tab(input int r);
      tab = '{16'(p1[r]), 16'(p2[r]), 16'(sp[r]), 16'(i1[r]), 16'(r < 9 ? t2[r] : 25), 16'(t2[r])};
   endfunction

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic tmo;
      error_cnt++;
      finish_test;
   endtask

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) tmo();
      end while (ack !== 1'b1);
      rdat = rdo;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   task automatic press(input int b);
      keys[b] <= 1'b1;
      repeat (2) @(posedge clk);
      keys[b] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic tune(input int r, input int kind, input int at, input logic l, input int ab);
      int n, t, k;
      logic err;
      logic [15:0] e;
      lf = lfsr(lf);
      e = {lf, ~lf};
      press(2);
      repeat (16) press(1);
      repeat (r) press(0);
      chk(rig_o, r);
      press(2);
      kind_r <= 2'(kind); at_r <= 16'(at); ld <= l; est_r <= e;
      servo <= 1'b1; keys[0] <= 1'b1;
      n = 0;
      while (run !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > 50) tmo();
      end
      chk(n >= HLD, 1);
      keys[0] <= 1'b0; fpro <= 1'b1; rpro <= 1'b1;
      t = 0;
      while (run === 1'b1) begin
         @(posedge clk);
         t++;
         if (t > 6 * CYC) tmo();
         k = t / CYC + 1;
         if ((at == 0 || t < at) && t % CYC == CYC / 4) chk({ash, rev}, {3'(k < 3 ? 0 : k - 2), 1'b0});
         if ((at == 0 || t < at) && t % CYC == 3 * CYC / 4) chk(rev, 1);
         if (t == 2) chk({pf, pr}, 0);
         if (t == at && ab == 2) servo <= 1'b0;
         else if (t == at && ab != 0) abv[ab] <= 1'b1;
      end
      if (at == 0) chk(t >= 5 * CYC - 2 && t <= 5 * CYC + 2, 1);
      else chk(t >= at - 1 && t <= at + 4, 1);
      err = ab != 0 || kind == 1 || kind == 2;
      if (!err && (kind == 0 || !l)) begin
         g = tab(r);
         ratio = l ? e : 16'h0000;
      end
      repeat (3) @(posedge clk);
      chk(gains, g);
      rd(8'h04, {29'h0, ~err, err, 1'b0});
      rd(8'h0C, {16'h0, ratio});
      rd(8'h18, {g.spd, g.spd});
      rd(8'h1C, {16'h03E8, g.int1});
      rd(8'h20, {g.trq2, g.trq1});
      chk({pf, pr}, 2'b11);
      abv <= 5'h00; servo <= 1'b0; fpro <= 1'b0; rpro <= 1'b0; kind_r <= 2'h3;
      $display("tune rig %0d kind %0d abort %0d ended", r, kind, ab);
   endtask

   initial begin
      {cyc, stb, we, servo, ld, fpro, rpro} = 7'h00;
      keys = 3'h0; abv = 5'h00; adr = 8'h00; wdat = 32'h0; kind_r = 2'h3;
      at_r = 16'h0; est_r = 16'h0; lf = 8'h5E; ratio = 16'h0;
      sel = 4'hF;
      error_cnt = 0; checks_done = 0;
      rst = 1'b1;
      g = tab(0);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({gains, rig_o, run}, {g, 4'h0, 1'b0});
      rd(8'h04, 32'h0);
      rd(8'h24, 32'h0032012C);
      rd(8'h28, 32'h000A0001);
      rd(8'h2C, 32'h0032001E);
      rd(8'h30, 32'h00140021);
      rd(8'h34, 32'h0);
      wb(1'b1, 8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0);
      wb(1'b1, 8'h00, 32'h1);
      rd(8'h04, 32'h8);
      wb(1'b1, 8'h00, 32'h0);
      rd(8'h00, 32'h0);
      wb(1'b1, 8'h08, 32'h3);
      rd(8'h08, 32'h3);
      wb(1'b1, 8'h08, 32'h0);
      rd(8'h08, 32'h0);
      sel <= 4'h0;
      wb(1'b1, 8'h08, 32'h2);
      sel <= 4'hF;
      rd(8'h08, 32'h0);
      repeat (17) press(0);
      chk(rig_o, 4'hF);
      press(2);
      for (int r = 0; r < 16; r++) tune(r, 0, 5, 1'b1, 0);
      tune(lf[3:0], 0, CYC + 7, 1'b0, 0);
      tune(lf[3:0], 3, 0, 1'b0, 0);
      tune(lf[3:0], 3, 0, 1'b1, 0);
      for (int a = 1; a < 7; a++) tune(lf[3:0], a > 4 ? a - 4 : 3, 2 * CYC + lf[4:0], 1'b1,
                                       a > 4 ? 0 : a);
      tune(lf[3:0], 0, 3 * CYC + 9, 1'b1, 0);
      finish_test;
   end
endmodule
